// [rtl/sos_pkg.sv]
/*
  package for the system oscillator select block: register offsets,
  field positions, reset values, encodings and oscillator rate constants.
  assumes a 50 MHz register clock and 32-bit AXI4-Lite data.
*/
package sos_pkg;
  // clock rate of the block
  localparam longint CLK_HZ = 64'd50000000;
  // oscillator nominal rates in Hz
  localparam longint RC_8M_HZ  = 64'd8000000;
  localparam longint RC_12M_HZ = 64'd12000000;
  localparam longint RC_16M_HZ = 64'd16000000;
  localparam longint SLOW_RC_HZ = 64'd32000;
  localparam longint SLOW_XTAL_MHZ = 64'd32768; // 32.768 kHz, in mHz/1000
  // phase steps of the 32-bit rate generators
  localparam logic [31:0] INC_RC_8M  = 32'((RC_8M_HZ << 32) / CLK_HZ);
  localparam logic [31:0] INC_RC_12M = 32'((RC_12M_HZ << 32) / CLK_HZ);
  localparam logic [31:0] INC_RC_16M = 32'((RC_16M_HZ << 32) / CLK_HZ);
  localparam logic [31:0] INC_SLOW_RC = 32'((SLOW_RC_HZ << 32) / CLK_HZ);
  // byte offsets of the registers
  localparam logic [4:0] OFS_SYSCTL = 5'h00;
  localparam logic [4:0] OFS_RCF  = 5'h04;
  localparam logic [4:0] OFS_XS   = 5'h08;
  localparam logic [4:0] OFS_PINS = 5'h0C;
  // system clock control field positions
  localparam int SYSCTL_SEL_LSB = 5;
  localparam int SYSCTL_FAST_SRC = 3;
  localparam int SYSCTL_SLOW_SRC = 2;
  localparam int SYSCTL_FHIDEN = 1;
  localparam int SYSCTL_FSIDEN = 0;
  // fast rc control field positions
  localparam int RCF_FREQ_LSB = 2;
  localparam int RCF_READY = 1;
  // slow crystal control field positions
  localparam int XS_SPEEDUP = 2;
  localparam int XS_READY = 1;
  localparam int XS_ENABLE = 0;
  // pin sharing field position
  localparam int PINS_OSC = 0;
  // encodings
  localparam logic [2:0] SEL_SLOW = 3'h7;
  localparam logic FAST_SRC_XTAL = 1'b0;
  localparam logic FAST_SRC_RC = 1'b1;
  localparam logic SLOW_SRC_RC = 1'b0;
  localparam logic SLOW_SRC_XTAL = 1'b1;
  localparam logic [1:0] FREQ_8M = 2'h0;
  localparam logic [1:0] FREQ_12M = 2'h1;
  localparam logic [1:0] FREQ_16M = 2'h2;
  // reset values
  localparam logic [2:0] RST_SEL = 3'h0;
  localparam logic [1:0] RST_FREQ = FREQ_8M;
  localparam logic RST_SPEEDUP = 1'b1;
  // slow crystal start-up, in crystal cycles
  localparam logic [12:0] SU_START_CYC = 13'h0400;
  localparam logic [12:0] LP_START_CYC = 13'h1000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sos_pkg

// [rtl/sos_top.sv]
/*
  system oscillator select: chooses fast and slow oscillator paths,
  divides the fast path, models the fast rc trim rates and the slow
  crystal start-up, and issues one-cycle clock enables.
  assumes one 50 MHz clock, crystal signals arriving on pins, a cpu
  halt level from logic on the same clock, and an AXI4-Lite master.
*/
// Functional notes
// - select field picks fast or slow path, live
// - low-speed select bit picks slow crystal or rc
// - high-speed select bit picks fast crystal or rc
// - fast rc runs at 8, 12 or 16 MHz
// - one fast and one slow source always chosen
// - slow crystal usable only after start-up delay
// - speed-up bit: one fast start, zero low power
// - low power mode only lengthens start-up
// - crystal mode frozen while it clocks system
// - pin-sharing bit gives crystal pins oscillator or io
// - halt stops system clock, peripherals may run
// - slow rc 32 kHz, slow crystal 32.768 kHz
// - fast path divided by 1 to 64
`timescale 1ns/10ps
module sos_top
  import sos_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // oscillator pins and halt
  input  wire logic        fastXtalIn,
  input  wire logic        slowXtalIn,
  input  wire logic        cpuHalt,
  // clock enables and status
  output logic             sysClkEn,
  output logic             fastPeriphEn,
  output logic             slowPeriphEn,
  output logic             slowXtalPinsOsc,
  // axi write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [4:0]  s_axi_awaddr,
  // axi write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [4:0]  s_axi_araddr,
  // axi read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);

  // whole state of the block
  typedef struct packed {
    logic        awHave;     // write address held
    logic [4:0]  awAddr;     // held write address
    logic        wHave;      // write data held
    logic [7:0]  wData;      // held low write byte
    logic        wStrb0;     // held low byte enable
    logic        awReady;    // write address ready
    logic        wReady;     // write data ready
    logic        bValid;     // write response valid
    logic [1:0]  bResp;      // write response code
    logic        arReady;    // read address ready
    logic        rValid;     // read data valid
    logic [7:0]  rData;      // read data byte
    logic [1:0]  rResp;      // read response code
    logic [2:0]  clkSel;     // sys_clk_select_field
    logic        fastSrcSel; // high_speed_src_sel
    logic        slowSrcSel; // low_speed_src_sel
    logic        fhiden;     // fast peripheral clock in halt
    logic        fsiden;     // slow peripheral clock in halt
    logic [1:0]  rcFreq;     // rc_fast_freq_sel
    logic        xsEn;       // xtal_slow_enable
    logic        xsSpeedup;  // xtal_slow_speedup
    logic        xsReady;    // slow crystal started
    logic [12:0] xsCnt;      // start-up crystal cycles
    logic        pinOsc;     // crystal pins serve the oscillator
    logic [1:0]  fxSync;     // fast crystal synchroniser
    logic        fxPrev;     // fast crystal last level
    logic [1:0]  sxSync;     // slow crystal synchroniser
    logic        sxPrev;     // slow crystal last level
    logic [31:0] rcAcc;      // fast rc phase
    logic [31:0] slowRcAcc;  // slow rc phase
    logic [5:0]  divCnt;     // fast path divider count
    logic        sysEn;      // system clock enable
    logic        fastEn;     // fast peripheral enable
    logic        slowEn;     // slow peripheral enable
  } sos_state_t;

  sos_state_t s_q;  // registered state
  sos_state_t s_d;  // next state

  // combinational ticks, shared with the checks
  logic        rcTick;      // fast rc edge
  logic        slowRcTick;  // slow rc edge
  logic        fxTick;      // fast crystal edge
  logic        xtalTick;    // slow crystal edge
  logic        fastTick;    // chosen fast source edge
  logic        slowTick;    // chosen slow source edge
  logic        divPulse;    // divided fast path edge
  logic        xtalActive;  // slow crystal drives the system clock
  logic [32:0] rcSum;       // fast rc phase step
  logic [32:0] slowRcSum;   // slow rc phase step

  // address decode shared by both channels
  function automatic logic isMapped(input logic [4:0] a);
    isMapped = (a == OFS_SYSCTL) || (a == OFS_RCF) || (a == OFS_XS) || (a == OFS_PINS);
  endfunction : isMapped

  // phase step of the fast rc for a frequency code
  function automatic logic [31:0] rcInc(input logic [1:0] f);
    case (f)
      FREQ_12M: rcInc = INC_RC_12M;
      FREQ_16M: rcInc = INC_RC_16M;
      default:  rcInc = INC_RC_8M;  // unused code runs at the lowest rate
    endcase
  endfunction : rcInc

  // next-state logic
  always_comb begin
    s_d = s_q;
    // oscillator models
    rcSum = {1'b0, s_q.rcAcc} + {1'b0, rcInc(s_q.rcFreq)};
    slowRcSum = {1'b0, s_q.slowRcAcc} + {1'b0, INC_SLOW_RC};
    rcTick = rcSum[32];
    slowRcTick = slowRcSum[32];
    s_d.rcAcc = rcSum[31:0];
    s_d.slowRcAcc = slowRcSum[31:0];
    // pin synchronisers and edge detect
    s_d.fxSync = {s_q.fxSync[0], fastXtalIn};
    s_d.sxSync = {s_q.sxSync[0], slowXtalIn};
    s_d.fxPrev = s_q.fxSync[1];
    s_d.sxPrev = s_q.sxSync[1];
    fxTick = s_q.fxSync[1] & ~s_q.fxPrev;
    // crystal edges count only while pins serve the oscillator
    xtalTick = s_q.sxSync[1] & ~s_q.sxPrev & s_q.pinOsc & s_q.xsEn;
    // source choice: one bit each, so no empty selection exists
    fastTick = (s_q.fastSrcSel == FAST_SRC_RC) ? rcTick : fxTick;
    slowTick = (s_q.slowSrcSel == SLOW_SRC_XTAL) ? (xtalTick & s_q.xsReady)
                                                 : slowRcTick;
    xtalActive = (s_q.clkSel == SEL_SLOW) && (s_q.slowSrcSel == SLOW_SRC_XTAL);
    // fast path divider, ratio 2**select
    divPulse = 1'b0;
    if (fastTick) begin
      if (s_q.divCnt >= 6'((7'h01 << s_q.clkSel) - 7'h01)) begin
        s_d.divCnt = 6'h00;
        divPulse = 1'b1;
      end else begin
        s_d.divCnt = s_q.divCnt + 6'h01;
      end
    end
    // system and peripheral enables
    s_d.sysEn = ~cpuHalt & ((s_q.clkSel == SEL_SLOW) ? slowTick : divPulse);
    s_d.fastEn = fastTick & (~cpuHalt | s_q.fhiden);
    s_d.slowEn = slowTick & (~cpuHalt | s_q.fsiden);
    // slow crystal start-up
    if (!s_q.xsEn) begin
      s_d.xsCnt = 13'h0000;
      s_d.xsReady = 1'b0;
    end else if (xtalTick && !s_q.xsReady) begin
      s_d.xsCnt = s_q.xsCnt + 13'h0001;
      // low power start takes longer, running is identical
      if (s_d.xsCnt >= (s_q.xsSpeedup ? SU_START_CYC : LP_START_CYC)) begin
        s_d.xsReady = 1'b1;
      end
    end
    // write address and data taken in either order
    if (s_axi_awvalid && s_q.awReady) begin
      s_d.awHave = 1'b1;
      s_d.awAddr = s_axi_awaddr;
      s_d.awReady = 1'b0;
    end
    if (s_axi_wvalid && s_q.wReady) begin
      s_d.wHave = 1'b1;
      s_d.wData = s_axi_wdata[7:0];
      s_d.wStrb0 = s_axi_wstrb[0];
      s_d.wReady = 1'b0;
    end
    // register write once both halves are in
    if (s_q.awHave && s_q.wHave && !s_q.bValid) begin
      s_d.awHave = 1'b0;
      s_d.wHave = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = isMapped(s_q.awAddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_q.wStrb0) begin
        case (s_q.awAddr)
          OFS_SYSCTL: begin
            s_d.clkSel = s_q.wData[SYSCTL_SEL_LSB +: 3];
            s_d.fastSrcSel = s_q.wData[SYSCTL_FAST_SRC];
            s_d.slowSrcSel = s_q.wData[SYSCTL_SLOW_SRC];
            s_d.fhiden = s_q.wData[SYSCTL_FHIDEN];
            s_d.fsiden = s_q.wData[SYSCTL_FSIDEN];
          end
          OFS_RCF: begin
            s_d.rcFreq = s_q.wData[RCF_FREQ_LSB +: 2];
          end
          OFS_XS: begin
            s_d.xsEn = s_q.wData[XS_ENABLE];
            // mode is frozen while the crystal clocks the system
            if (!xtalActive) begin
              s_d.xsSpeedup = s_q.wData[XS_SPEEDUP];
            end
          end
          OFS_PINS: begin
            s_d.pinOsc = s_q.wData[PINS_OSC];
          end
          default: begin
            // unmapped: nothing stored
          end
        endcase
      end
    end
    // write response handshake reopens both channels
    if (s_q.bValid && s_axi_bready) begin
      s_d.bValid = 1'b0;
      s_d.awReady = 1'b1;
      s_d.wReady = 1'b1;
    end
    // read channel
    if (s_axi_arvalid && s_q.arReady) begin
      s_d.arReady = 1'b0;
      s_d.rValid = 1'b1;
      s_d.rResp = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFS_SYSCTL: begin
          s_d.rData = {s_q.clkSel, 1'b0, s_q.fastSrcSel, s_q.slowSrcSel, s_q.fhiden, s_q.fsiden};
        end
        OFS_RCF: begin
          s_d.rData = {4'h0, s_q.rcFreq, 1'b1, 1'b0};
        end
        OFS_XS: begin
          s_d.rData = {5'h00, s_q.xsSpeedup, s_q.xsReady, s_q.xsEn};
        end
        OFS_PINS: begin
          s_d.rData = {7'h00, s_q.pinOsc};
        end
        default: begin
          s_d.rData = 8'h00;
        end
      endcase
    end else if (s_q.rValid && s_axi_rready) begin
      s_d.rValid = 1'b0;
      s_d.arReady = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.awReady <= 1'b1;
      s_q.wReady <= 1'b1;
      s_q.arReady <= 1'b1;
      s_q.clkSel <= RST_SEL;
      s_q.rcFreq <= RST_FREQ;
      s_q.xsSpeedup <= RST_SPEEDUP;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign sysClkEn = s_q.sysEn;
  assign fastPeriphEn = s_q.fastEn;
  assign slowPeriphEn = s_q.slowEn;
  assign slowXtalPinsOsc = s_q.pinOsc;
  assign s_axi_awready = s_q.awReady;
  assign s_axi_wready = s_q.wReady;
  assign s_axi_bvalid = s_q.bValid;
  assign s_axi_bresp = s_q.bResp;
  assign s_axi_arready = s_q.arReady;
  assign s_axi_rvalid = s_q.rValid;
  assign s_axi_rdata = {24'h000000, s_q.rData};
  assign s_axi_rresp = s_q.rResp;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_slow_path_sel: assert property (
    (s_q.clkSel == SEL_SLOW) && !cpuHalt && slowTick |=> sysClkEn)
    else $error("slow path edge did not reach system clock");
  chk_slow_rc_pick: assert property (
    (s_q.slowSrcSel == SLOW_SRC_RC) |-> (slowTick == slowRcTick))
    else $error("slow rc not used as slow source");
  chk_fast_src_pick: assert property (
    (s_q.fastSrcSel == FAST_SRC_RC) |-> (fastTick == rcTick))
    else $error("fast rc not used as fast source");
  chk_rc_rate: assert property (
    rcTick |=> !rcTick)
    else $error("fast rc edges too close");
  chk_one_source: assert property (
    fastTick |-> (rcTick || fxTick))
    else $error("fast edge without a source");
  chk_xtal_wait: assert property (
    !s_q.xsEn |=> !s_q.xsReady ##1 !slowTick || s_q.slowSrcSel == SLOW_SRC_RC || s_q.xsReady)
    else $error("slow crystal ready while disabled");
  chk_speedup_lock: assert property (
    xtalActive && $stable(xtalActive) |=> $stable(s_q.xsSpeedup))
    else $error("crystal mode changed while active");
  chk_halt_stop: assert property (
    cpuHalt |=> !sysClkEn)
    else $error("system clock ran during halt");
  chk_div_one: assert property (
    (s_q.clkSel == 3'h0) && fastTick && !cpuHalt |=> sysClkEn)
    else $error("undivided fast edge lost");
  chk_pins_io: assert property (
    !s_q.pinOsc |-> !xtalTick)
    else $error("crystal edge counted with pins as io");
  // slow crystal start-up lengths and halt gating of the peripheral enables
  chk_xtal_su_cnt: assert property (
    $rose(s_q.xsReady) |-> (s_q.xsCnt >= SU_START_CYC))
    else $error("slow crystal ready before start-up count");
  chk_xtal_lp_cnt: assert property (
    $rose(s_q.xsReady) && !$past(s_q.xsSpeedup) |-> (s_q.xsCnt >= LP_START_CYC))
    else $error("low power start-up cut short");
  chk_halt_fast_periph: assert property (
    cpuHalt && !s_q.fhiden |=> !fastPeriphEn)
    else $error("fast peripheral enable ran in halt");
  chk_halt_slow_periph: assert property (
    cpuHalt && !s_q.fsiden |=> !slowPeriphEn)
    else $error("slow peripheral enable ran in halt");

  cov_slow_run: cover property (xtalActive && sysClkEn);
  cov_xtal_start: cover property ($rose(s_q.xsReady));
  cov_halt_periph: cover property (cpuHalt && fastPeriphEn);
  cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  cov_lp_start: cover property ($rose(s_q.xsReady) && !s_q.xsSpeedup);

endmodule : sos_top

// [verif/sos_top_tb.sv]
/*
  self-checking bench for sos_top: register access over axi, fast path
  divide, fast rc rates, halt gating, slow crystal start-up and lock.
  assumes the sos_pkg constants and the slave timing of the hand-over.
*/
`timescale 1ns/10ps
module sos_top_tb;
  import sos_pkg::*;
  // clock, reset, pins
  logic        clock, rst_n, cpuHalt, fastXtalIn, slowXtalIn;
  logic        fxRun, sxRun;         // crystal generators on
  logic [1:0]  phase;                // crystal waveform divider
  logic        sysClkEn, fastPeriphEn, slowPeriphEn, slowXtalPinsOsc;
  // axi
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  // bookkeeping
  int          errTotal, numChecks, cycles, nSys, nFast, nSlow;

  sos_top DUT (.clock, .rst_n, .fastXtalIn, .slowXtalIn, .cpuHalt, .sysClkEn,
    .fastPeriphEn, .slowPeriphEn, .slowXtalPinsOsc, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // crystal waveforms: one rising edge every four clocks while running
  always @(posedge clock) begin
    phase <= phase + 2'h1;
    fastXtalIn <= fxRun & phase[1];
    slowXtalIn <= sxRun & phase[1];
  end

  // hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      errTotal++;
      results();
    end
  end

  // one comparison
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  // a pulse count within a tolerance
  task near(input string name, input int seen, input int exp, input int tol);
    check(name, 32'(((seen >= exp - tol) && (seen <= exp + tol)) ? exp : seen), 32'(exp));
  endtask : near

  // axi write: address and data offered together, each released when taken
  task wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  // axi read into rd and rsp
  task rdr(input logic [4:0] a);
    @(posedge clock);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd  = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr

  // count enable pulses over n cycles
  task count(input int n);
    nSys  = 0;
    nFast = 0;
    nSlow = 0;
    repeat (n) begin
      @(posedge clock);
      nSys  += int'(sysClkEn === 1'b1);
      nFast += int'(fastPeriphEn === 1'b1);
      nSlow += int'(slowPeriphEn === 1'b1);
    end
  endtask : count

  // system clock control word
  function automatic logic [31:0] sysctl(input logic [2:0] s, input logic h, input logic l,
                                         input logic hid, input logic sid);
    return 32'(s) << SYSCTL_SEL_LSB | 32'(h) << SYSCTL_FAST_SRC | 32'(l) << SYSCTL_SLOW_SRC
           | 32'(hid) << SYSCTL_FHIDEN | 32'(sid) << SYSCTL_FSIDEN;
  endfunction : sysctl

  // reset values, two unmapped places and a write without the low byte lane
  task t_reset;
    rdr(OFS_SYSCTL);
    check("sysctl reset", rd, 32'h00);
    rdr(OFS_RCF);
    check("rcf reset", rd, 32'h02);
    rdr(OFS_XS);
    check("xs reset", rd, 32'h04);
    check("pins reset", 32'(slowXtalPinsOsc), 32'h0);
    rdr(5'h10);
    check("unmapped read", 32'(rsp), 32'(RESP_SLVERR));
    wr(5'h14, 32'hFF);
    check("unmapped write", 32'(rsp), 32'(RESP_SLVERR));
    s_axi_wstrb <= 4'hE;
    wr(OFS_PINS, 32'h01);
    check("no lane response", 32'(rsp), 32'(RESP_OKAY));
    check("no lane pins", 32'(slowXtalPinsOsc), 32'h0);
    s_axi_wstrb <= 4'hF;
    $display("test reset done");
  endtask : t_reset

  // fast crystal divided by 1, 4 and 64, changed on the fly
  task t_div;
    fxRun <= 1'b1;
    for (int s = 0; s <= 6; s += 2) begin
      if (s == 4) s = 6;
      wr(OFS_SYSCTL, sysctl(3'(s), FAST_SRC_XTAL, SLOW_SRC_RC, 1'b0, 1'b0));
      count(1024);
      near("divided edges", nSys, 256 >> s, 2);
    end
    $display("test divide done");
  endtask : t_div

  // halt stops system enable; fast peripheral enable follows its idle bit
  task t_halt;
    wr(OFS_SYSCTL, sysctl(3'h0, FAST_SRC_XTAL, SLOW_SRC_RC, 1'b1, 1'b0));
    cpuHalt <= 1'b1;
    // the enable launched at this edge still saw the cpu running
    @(posedge clock);
    count(200);
    near("halt sys", nSys, 0, 0);
    near("halt fast on", nFast, 50, 2);
    wr(OFS_SYSCTL, sysctl(3'h0, FAST_SRC_XTAL, SLOW_SRC_RC, 1'b0, 1'b0));
    count(200);
    near("halt fast off", nFast, 0, 0);
    cpuHalt <= 1'b0;
    $display("test halt done");
  endtask : t_halt

  // fast rc at 8, 12 and 16 MHz
  task t_rc;
    for (int f = 0; f < 3; f++) begin
      wr(OFS_RCF, 32'(f) << RCF_FREQ_LSB);
      wr(OFS_SYSCTL, sysctl(3'h0, FAST_SRC_RC, SLOW_SRC_RC, 1'b0, 1'b0));
      count(1000);
      near("rc edges", nSys, 160 + 80 * f, 2);
      rdr(OFS_RCF);
      check("rc freq field", rd, 32'(f) << RCF_FREQ_LSB | 32'h02);
    end
    $display("test rc done");
  endtask : t_rc

  // slow crystal start-up in both modes, mode lock while selected, drop to low power
  task t_slow;
    wr(OFS_PINS, 32'h01);
    check("pins osc", 32'(slowXtalPinsOsc), 32'h1);
    wr(OFS_XS, 32'h05);
    sxRun <= 1'b1;
    repeat (4000) @(posedge clock);
    rdr(OFS_XS);
    check("xs early", rd, 32'h05);
    repeat (240) @(posedge clock);
    rdr(OFS_XS);
    check("xs ready", rd, 32'h07);
    wr(OFS_SYSCTL, sysctl(SEL_SLOW, FAST_SRC_XTAL, SLOW_SRC_XTAL, 1'b0, 1'b0));
    count(400);
    near("slow xtal edges", nSys, 100, 2);
    wr(OFS_XS, 32'h01);
    rdr(OFS_XS);
    check("mode locked", rd, 32'h07);
    wr(OFS_SYSCTL, sysctl(3'h0, FAST_SRC_XTAL, SLOW_SRC_XTAL, 1'b0, 1'b0));
    wr(OFS_XS, 32'h01);
    rdr(OFS_XS);
    check("speedup dropped", rd, 32'h03);
    count(400);
    near("low power edges", nSlow, 100, 2);
    wr(OFS_XS, 32'h00);
    wr(OFS_XS, 32'h01);
    repeat (16000) @(posedge clock);
    rdr(OFS_XS);
    check("lp early", rd, 32'h01);
    repeat (600) @(posedge clock);
    rdr(OFS_XS);
    check("lp ready", rd, 32'h03);
    sxRun <= 1'b0;
    $display("test slow crystal done");
  endtask : t_slow

  // slow rc near 32 kHz as system clock, then kept for peripherals in halt
  task t_slowrc;
    wr(OFS_SYSCTL, sysctl(SEL_SLOW, FAST_SRC_XTAL, SLOW_SRC_RC, 1'b0, 1'b1));
    count(25000);
    near("slow rc edges", nSys, 16, 1);
    near("slow rc periph", nSlow, 16, 1);
    cpuHalt <= 1'b1;
    @(posedge clock);
    count(6250);
    near("halt slow sys", nSys, 0, 0);
    near("halt slow periph", nSlow, 4, 1);
    cpuHalt <= 1'b0;
    $display("test slow rc done");
  endtask : t_slowrc

  // counts and verdict
  task results;
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // main sequence
  initial begin
    {rst_n, cpuHalt, fxRun, sxRun, phase} = '0;
    {fastXtalIn, slowXtalIn, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {errTotal, numChecks, cycles} = '0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_div();
    t_halt();
    t_rc();
    t_slow();
    t_slowrc();
    results();
  end
endmodule : sos_top_tb
